/* File: include/pad_mux_regs.vh */
// Operation
// - pad a0 mux: mic data, pwm0 complement, uart rx
// - pad a1 mux: mic clock, card clock, i2s clock
// - pad a3 mux: spi in, uart cts, pwm1
// - pad a4 mux: spi clock, uart rts, pwm2
// - pad b0 mux: pwm3, uart rx, antenna one
// - port b input/drive bits in separate registers
// - pad b6 resets to spi data in
// - pad b7 resets to spi data out
// - pad c0 mux; port c input/drive separate
// - pad c3 mux: pwm1, uart rx, i2c clock
// - pad c5 mux: pwm3 complement, uart rx, antenna zero
// - pad d0 mux: receive amp, none, card transceive
// - output disable bit low drives the pad in gpio mode
// - input pass bit low forces input zero
// - gpio select overrides the peripheral function
// - drive strength resets high
`ifndef PAD_MUX_REGS_VH
`define PAD_MUX_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_A_LEVEL 11'h580
`define IDX_A_IE 11'h581
`define IDX_A_OEN 11'h582
`define IDX_A_OUT 11'h583
`define IDX_A_POL 11'h584
`define IDX_A_DS 11'h585
`define IDX_A_GPIO 11'h586
`define IDX_B_LEVEL 11'h588
`define IDX_B_OEN 11'h58a
`define IDX_B_OUT 11'h58b
`define IDX_B_POL 11'h58c
`define IDX_B_GPIO 11'h58e
`define IDX_C_LEVEL 11'h590
`define IDX_C_OEN 11'h592
`define IDX_C_OUT 11'h593
`define IDX_C_POL 11'h594
`define IDX_C_GPIO 11'h596
`define IDX_D_LEVEL 11'h598
`define IDX_D_IE 11'h599
`define IDX_D_OEN 11'h59a
`define IDX_D_OUT 11'h59b
`define IDX_D_POL 11'h59c
`define IDX_D_DS 11'h59d
`define IDX_D_GPIO 11'h59e
`define IDX_FSEL0 11'h5a8
`define IDX_FSEL1 11'h5a9
`define IDX_FSEL2 11'h5aa
`define IDX_FSEL3 11'h5ab
`define IDX_FSEL4 11'h5ac
`define IDX_FSEL5 11'h5ad
`define IDX_FSEL6 11'h5ae
// analog-side port b / c input pass and drive strength
`define IDX_B_IE 11'h5b0
`define IDX_B_DS 11'h5b1
`define IDX_C_IE 11'h5b2
`define IDX_C_DS 11'h5b3

// ----------------------------------------------------------------
// reset values, one bit per pad (a = 7:0 ... d = 31:24), two bits per pad for the selects
// ----------------------------------------------------------------
`define RST_IE 32'h0000c000
`define RST_OEN 32'hffffffff
`define RST_OUT 32'h00000000
`define RST_POL 32'h00000000
`define RST_DS 32'hffffffff
`define RST_GPIO 32'hffff3f7f
`define RST_FSEL 56'h00000050000000

`endif

/* File: core/pad_function_mux_gpio.v */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "pad_mux_regs.vh"

module pad_function_mux_gpio (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // peripheral side, one bit per function id
    input wire [37:0] func_out,
    input wire [37:0] func_oe,
    output reg [37:0] func_in,
    // pad side, one bit per pad
    input wire [31:0] pad_in,
    output reg [31:0] pad_out,
    output reg [31:0] pad_oe,
    output reg [31:0] pad_drive_strength,
    output reg [31:0] gpio_polarity
);

// ----------------------------------------------------------------
// function ids (0 means nothing is connected)
// ----------------------------------------------------------------
localparam [5:0] F_NONE = 6'h00;
localparam [5:0] F_MIC_DI = 6'h01;
localparam [5:0] F_MIC_CLK = 6'h02;
localparam [5:0] F_PWM0 = 6'h03;
localparam [5:0] F_PWM1 = 6'h04;
localparam [5:0] F_PWM2 = 6'h05;
localparam [5:0] F_PWM3 = 6'h06;
localparam [5:0] F_PWM4 = 6'h07;
localparam [5:0] F_PWM5 = 6'h08;
localparam [5:0] F_PWM0_C = 6'h09;
localparam [5:0] F_PWM1_C = 6'h0a;
localparam [5:0] F_PWM3_C = 6'h0b;
localparam [5:0] F_PWM4_C = 6'h0c;
localparam [5:0] F_PWM5_C = 6'h0d;
localparam [5:0] F_UART_RX = 6'h0e;
localparam [5:0] F_UART_TX = 6'h0f;
localparam [5:0] F_UART_CTS = 6'h10;
localparam [5:0] F_UART_RTS = 6'h11;
localparam [5:0] F_CARD_CLK = 6'h12;
localparam [5:0] F_CARD_TRX = 6'h13;
localparam [5:0] F_I2S_CLK = 6'h14;
localparam [5:0] F_SPI_DO = 6'h15;
localparam [5:0] F_SPI_DI = 6'h16;
localparam [5:0] F_SPI_CLK = 6'h17;
localparam [5:0] F_USB_MINUS = 6'h18;
localparam [5:0] F_USB_PLUS = 6'h19;
localparam [5:0] F_SWIRE = 6'h1a;
localparam [5:0] F_ANT_ZERO = 6'h1b;
localparam [5:0] F_ANT_ONE = 6'h1c;
localparam [5:0] F_ANT_TWO = 6'h1d;
localparam [5:0] F_RX_AMP = 6'h1e;
localparam [5:0] F_TX_AMP = 6'h1f;
localparam [5:0] F_SD_POS0 = 6'h20;
localparam [5:0] F_SD_NEG0 = 6'h21;
localparam [5:0] F_SD_POS1 = 6'h22;
localparam [5:0] F_SD_NEG1 = 6'h23;
localparam [5:0] F_I2C_SDA = 6'h24;
localparam [5:0] F_I2C_SCK = 6'h25;

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
localparam PAD_COUNT = 32;
localparam SEL_PADS = 28; // pads with a select field in the map
localparam [1:0] SEL_UNDEF = 2'h3;

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg [31:0] ie_q; // input pass bits
reg [31:0] oen_q; // output disable bits, low drives
reg [31:0] out_q; // gpio output values
reg [31:0] pol_q; // polarity, handed to the edge logic outside
reg [31:0] ds_q; // drive strength
reg [31:0] gpio_q; // act-as-gpio bits
reg [55:0] fsel_q; // two select bits per pad, pads 0..27
reg [31:0] level_q; // sampled, gated pad levels
reg [31:0] pad_out_d;
reg [31:0] pad_oe_d;
reg [37:0] func_in_d;
reg [31:0] rdata_d;
reg hit_d;
reg [5:0] fid;
reg [1:0] sel;
integer p;

wire [10:0] idx = paddr[12:2]; // register index from the byte address
wire aligned = (paddr[1:0] == 2'h0) && (paddr[15:13] == 3'h0);
wire setup = psel && !penable;
wire wr_fire = psel && penable && pready && pwrite && !pslverr;

// ----------------------------------------------------------------
// pad mux table: {code 2, code 1, code 0} function ids per pad
// ----------------------------------------------------------------
function [17:0] pad_funcs;
    input [4:0] pad;
    begin
        case (pad)
            5'd0: pad_funcs = {F_UART_RX, F_PWM0_C, F_MIC_DI};
            5'd1: pad_funcs = {F_I2S_CLK, F_CARD_CLK, F_MIC_CLK};
            5'd2: pad_funcs = {F_PWM0, F_UART_TX, F_SPI_DO};
            5'd3: pad_funcs = {F_PWM1, F_UART_CTS, F_SPI_DI};
            5'd4: pad_funcs = {F_PWM2, F_UART_RTS, F_SPI_CLK};
            5'd5: pad_funcs = {F_NONE, F_NONE, F_USB_MINUS};
            5'd6: pad_funcs = {F_NONE, F_NONE, F_USB_PLUS};
            5'd7: pad_funcs = {F_NONE, F_UART_RTS, F_SWIRE};
            5'd8: pad_funcs = {F_ANT_ONE, F_UART_RX, F_PWM3};
            5'd9: pad_funcs = {F_ANT_TWO, F_UART_TX, F_PWM4};
            5'd10: pad_funcs = {F_RX_AMP, F_UART_CTS, F_PWM5};
            5'd11: pad_funcs = {F_TX_AMP, F_UART_RTS, F_PWM0_C};
            5'd12: pad_funcs = {F_NONE, F_PWM4, F_SD_POS0};
            5'd13: pad_funcs = {F_NONE, F_PWM5, F_SD_NEG0};
            5'd14: pad_funcs = {F_UART_RTS, F_SPI_DI, F_SD_POS1};
            5'd15: pad_funcs = {F_UART_RX, F_SPI_DO, F_SD_NEG1};
            5'd16: pad_funcs = {F_UART_RTS, F_PWM4_C, F_I2C_SDA};
            5'd17: pad_funcs = {F_PWM0, F_PWM1_C, F_I2C_SCK};
            5'd18: pad_funcs = {F_I2C_SDA, F_CARD_TRX, F_PWM0};
            5'd19: pad_funcs = {F_I2C_SCK, F_UART_RX, F_PWM1};
            5'd20: pad_funcs = {F_PWM0_C, F_UART_CTS, F_PWM2};
            5'd21: pad_funcs = {F_ANT_ZERO, F_UART_RX, F_PWM3_C};
            5'd22: pad_funcs = {F_PWM4_C, F_ANT_ONE, F_RX_AMP};
            5'd23: pad_funcs = {F_PWM5_C, F_ANT_TWO, F_TX_AMP};
            5'd24: pad_funcs = {F_CARD_TRX, F_NONE, F_RX_AMP};
            5'd25: pad_funcs = {F_UART_CTS, F_NONE, F_TX_AMP};
            default: pad_funcs = {F_NONE, F_NONE, F_NONE};
        endcase
    end
endfunction

// ----------------------------------------------------------------
// select code to function id; code 3 reaches nothing
// ----------------------------------------------------------------
function [5:0] func_id;
    input [4:0] pad;
    input [1:0] code;
    reg [17:0] row;
    begin
        row = pad_funcs(pad);
        case (code)
            2'h0: func_id = row[5:0];
            2'h1: func_id = row[11:6];
            2'h2: func_id = row[17:12];
            default: func_id = F_NONE;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// pad steering and function input gathering
// ----------------------------------------------------------------
// gpio wins over the mux; an undefined or empty code leaves the pad
// undriven. several pads may feed one function input: they are ored,
// so software must keep a function on one pad to avoid contention.
always @* begin
    pad_out_d = 32'h00000000;
    pad_oe_d = 32'h00000000;
    func_in_d = 38'h0000000000;
    fid = F_NONE;
    sel = 2'h0;
    for (p = 0; p < PAD_COUNT; p = p + 1) begin
        if (p < SEL_PADS) begin
            sel = fsel_q[2*p +: 2];
        end else begin
            sel = SEL_UNDEF;
        end
        fid = func_id(p[4:0], sel);
        if (gpio_q[p]) begin
            // gpio path: output disable is active high, low drives
            pad_out_d[p] = out_q[p];
            pad_oe_d[p] = ~oen_q[p];
        end else if (fid != F_NONE) begin
            // peripheral path: the function drives its own enable
            pad_out_d[p] = func_out[fid];
            pad_oe_d[p] = func_oe[fid];
            func_in_d[fid] = func_in_d[fid] | (pad_in[p] & ie_q[p]);
        end else begin
            // nothing selected: keep the pad quiet
            pad_out_d[p] = 1'b0;
            pad_oe_d[p] = 1'b0;
        end
    end
end

// ----------------------------------------------------------------
// read decode
// ----------------------------------------------------------------
always @* begin
    rdata_d = 32'h00000000;
    hit_d = aligned;
    case (idx)
        `IDX_A_LEVEL: rdata_d[7:0] = level_q[7:0];
        `IDX_A_IE: rdata_d[7:0] = ie_q[7:0];
        `IDX_A_OEN: rdata_d[7:0] = oen_q[7:0];
        `IDX_A_OUT: rdata_d[7:0] = out_q[7:0];
        `IDX_A_POL: rdata_d[7:0] = pol_q[7:0];
        `IDX_A_DS: rdata_d[7:0] = ds_q[7:0];
        `IDX_A_GPIO: rdata_d[7:0] = gpio_q[7:0];
        `IDX_B_LEVEL: rdata_d[7:0] = level_q[15:8];
        `IDX_B_OEN: rdata_d[7:0] = oen_q[15:8];
        `IDX_B_OUT: rdata_d[7:0] = out_q[15:8];
        `IDX_B_POL: rdata_d[7:0] = pol_q[15:8];
        `IDX_B_GPIO: rdata_d[7:0] = gpio_q[15:8];
        `IDX_B_IE: rdata_d[7:0] = ie_q[15:8];
        `IDX_B_DS: rdata_d[7:0] = ds_q[15:8];
        `IDX_C_LEVEL: rdata_d[7:0] = level_q[23:16];
        `IDX_C_OEN: rdata_d[7:0] = oen_q[23:16];
        `IDX_C_OUT: rdata_d[7:0] = out_q[23:16];
        `IDX_C_POL: rdata_d[7:0] = pol_q[23:16];
        `IDX_C_GPIO: rdata_d[7:0] = gpio_q[23:16];
        `IDX_C_IE: rdata_d[7:0] = ie_q[23:16];
        `IDX_C_DS: rdata_d[7:0] = ds_q[23:16];
        `IDX_D_LEVEL: rdata_d[7:0] = level_q[31:24];
        `IDX_D_IE: rdata_d[7:0] = ie_q[31:24];
        `IDX_D_OEN: rdata_d[7:0] = oen_q[31:24];
        `IDX_D_OUT: rdata_d[7:0] = out_q[31:24];
        `IDX_D_POL: rdata_d[7:0] = pol_q[31:24];
        `IDX_D_DS: rdata_d[7:0] = ds_q[31:24];
        `IDX_D_GPIO: rdata_d[7:0] = gpio_q[31:24];
        `IDX_FSEL0: rdata_d[7:0] = fsel_q[7:0];
        `IDX_FSEL1: rdata_d[7:0] = fsel_q[15:8];
        `IDX_FSEL2: rdata_d[7:0] = fsel_q[23:16];
        `IDX_FSEL3: rdata_d[7:0] = fsel_q[31:24];
        `IDX_FSEL4: rdata_d[7:0] = fsel_q[39:32];
        `IDX_FSEL5: rdata_d[7:0] = fsel_q[47:40];
        `IDX_FSEL6: rdata_d[7:0] = fsel_q[55:48];
        // unmapped index answers with an error
        default: hit_d = 1'b0;
    endcase
end

// ----------------------------------------------------------------
// apb handshake: one wait-free access phase after setup
// ----------------------------------------------------------------
// read data is captured at the setup edge, so a level read shows the
// pad state two cycles before the access completes.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else if (setup) begin
        pready <= 1'b1;
        pslverr <= !hit_d || (pwrite && level_idx(idx));
        prdata <= (hit_d && !pwrite) ? rdata_d : 32'h00000000;
    end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end
end

// level registers are read-only; a write to them is refused
function level_idx;
    input [10:0] i;
    begin
        level_idx = (i == `IDX_A_LEVEL) || (i == `IDX_B_LEVEL) ||
                    (i == `IDX_C_LEVEL) || (i == `IDX_D_LEVEL);
    end
endfunction

// ----------------------------------------------------------------
// register writes, taken at the completing edge
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ie_q <= `RST_IE;
        oen_q <= `RST_OEN;
        out_q <= `RST_OUT;
        pol_q <= `RST_POL;
        ds_q <= `RST_DS;
        gpio_q <= `RST_GPIO;
        fsel_q <= `RST_FSEL;
    end else if (wr_fire) begin
        case (idx)
            `IDX_A_IE: ie_q[7:0] <= pwdata[7:0];
            `IDX_A_OEN: oen_q[7:0] <= pwdata[7:0];
            `IDX_A_OUT: out_q[7:0] <= pwdata[7:0];
            `IDX_A_POL: pol_q[7:0] <= pwdata[7:0];
            `IDX_A_DS: ds_q[7:0] <= pwdata[7:0];
            `IDX_A_GPIO: gpio_q[7:0] <= pwdata[7:0];
            `IDX_B_OEN: oen_q[15:8] <= pwdata[7:0];
            `IDX_B_OUT: out_q[15:8] <= pwdata[7:0];
            `IDX_B_POL: pol_q[15:8] <= pwdata[7:0];
            `IDX_B_GPIO: gpio_q[15:8] <= pwdata[7:0];
            `IDX_B_IE: ie_q[15:8] <= pwdata[7:0];
            `IDX_B_DS: ds_q[15:8] <= pwdata[7:0];
            `IDX_C_OEN: oen_q[23:16] <= pwdata[7:0];
            `IDX_C_OUT: out_q[23:16] <= pwdata[7:0];
            `IDX_C_POL: pol_q[23:16] <= pwdata[7:0];
            `IDX_C_GPIO: gpio_q[23:16] <= pwdata[7:0];
            `IDX_C_IE: ie_q[23:16] <= pwdata[7:0];
            `IDX_C_DS: ds_q[23:16] <= pwdata[7:0];
            `IDX_D_IE: ie_q[31:24] <= pwdata[7:0];
            `IDX_D_OEN: oen_q[31:24] <= pwdata[7:0];
            `IDX_D_OUT: out_q[31:24] <= pwdata[7:0];
            `IDX_D_POL: pol_q[31:24] <= pwdata[7:0];
            `IDX_D_DS: ds_q[31:24] <= pwdata[7:0];
            `IDX_D_GPIO: gpio_q[31:24] <= pwdata[7:0];
            `IDX_FSEL0: fsel_q[7:0] <= pwdata[7:0];
            `IDX_FSEL1: fsel_q[15:8] <= pwdata[7:0];
            `IDX_FSEL2: fsel_q[23:16] <= pwdata[7:0];
            `IDX_FSEL3: fsel_q[31:24] <= pwdata[7:0];
            `IDX_FSEL4: fsel_q[39:32] <= pwdata[7:0];
            `IDX_FSEL5: fsel_q[47:40] <= pwdata[7:0];
            `IDX_FSEL6: fsel_q[55:48] <= pwdata[7:0];
            // read-only or unmapped: nothing changes
            default: fsel_q <= fsel_q;
        endcase
    end
end

// ----------------------------------------------------------------
// registered pad and function outputs
// ----------------------------------------------------------------
// registering costs one cycle of latency through the mux but keeps
// the pad drivers free of decode glitches.
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pad_out <= 32'h00000000;
        pad_oe <= 32'h00000000;
        func_in <= 38'h0000000000;
        level_q <= 32'h00000000;
        pad_drive_strength <= `RST_DS;
        gpio_polarity <= `RST_POL;
    end else begin
        pad_out <= pad_out_d;
        pad_oe <= pad_oe_d;
        func_in <= func_in_d;
        level_q <= pad_in & ie_q;
        pad_drive_strength <= ds_q;
        gpio_polarity <= pol_q;
    end
end

endmodule // pad_function_mux_gpio

/* File: dv/pad_mux_monitor.sv */
`timescale 1ns/1ns
// ----------------
// protocol and pad checks, bound to the block
// ----------------
module pad_mux_monitor (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // peripheral and pad side
    input wire [37:0] func_oe,
    input wire [37:0] func_in,
    input wire [31:0] pad_in,
    input wire [31:0] pad_oe,
    input wire [31:0] pad_drive_strength
);
    // one clock domain, so one clocking and one reset for all checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // zero-wait slave: the answer follows every setup cycle
    AST_PREADY_ACK:
        assert property (psel && !penable |=> pready) else $error("no answer after setup");
    AST_PREADY_PULSE:
        assert property (pready |=> !pready) else $error("answer held too long");
    AST_RDATA_IDLE:
        assert property (!pready |-> prdata == 32'h0) else $error("read data not cleared");
    AST_RDATA_UPPER:
        assert property (prdata[31:8] == 24'h0) else $error("read data upper bits set");
    AST_ERR_QUAL:
        assert property (pslverr |-> pready) else $error("error without answer");
    // the port a level register is read only: a write is refused
    AST_LEVEL_WRITE:
        assert property (psel && !penable && pwrite && paddr == 16'h1600 |=> pslverr && prdata == 32'h0)
        else $error("level write not refused");
    AST_DRIVE_RESET:
        assert property ($rose(presetn) |-> pad_drive_strength == 32'hffffffff) else $error("drive not high");
    // with no writes and quiet inputs the pad enables and function inputs must not move by themselves
    AST_OE_QUIET:
        assert property ((!(psel && pwrite) && $stable(func_oe) && $stable(presetn)) [*3] |-> $stable(pad_oe))
        else $error("pad enable moved without cause");
    AST_IN_QUIET:
        assert property ((!(psel && pwrite) && $stable(pad_in) && $stable(presetn)) [*3] |-> $stable(func_in))
        else $error("function input moved without cause");
endmodule // pad_mux_monitor

bind pad_function_mux_gpio pad_mux_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .func_oe, .func_in, .pad_in, .pad_oe, .pad_drive_strength);

/* File: dv/pad_world.sv */
`timescale 1ns/1ns
// ----------------
// circuitry on the package pads
// ----------------
module pad_world (
    // from the block
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    // outside drive chosen by the bench
    input wire logic [31:0] ext_level,
    // back to the block
    output logic [31:0] pad_in
);
    // a driven pad shows the block's value; an undriven one the outside level, never a stale copy
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule // pad_world

/* File: dv/pad_function_mux_gpio_bench.sv */
`timescale 1ns/1ns
`include "pad_mux_regs.vh"
// ----------------
// self-checking bench
// ----------------
module pad_function_mux_gpio_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr; // clock, reset, apb controls
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, pad_in, pad_out, pad_oe, pad_ds, pad_pol, ext_level, r;
    logic [37:0] func_out, func_oe, func_in;
    logic [8:0] expq[$]; // expected {error, data} per transfer, oldest first
    logic [39:0] e;
    logic [7:0] pin, dis, nd, lvl;
    int miscompares, cmp_count, id, lo;
    int seed = 32'h3bcdf2db;
    // reset values: index, value
    logic [18:0] rst_tab[15] = '{{`IDX_A_IE, 8'h00}, {`IDX_A_OEN, 8'hff}, {`IDX_A_OUT, 8'h00}, {`IDX_A_POL, 8'h00},
        {`IDX_A_DS, 8'hff}, {`IDX_A_GPIO, 8'h7f}, {`IDX_B_IE, 8'hc0}, {`IDX_B_DS, 8'hff}, {`IDX_B_GPIO, 8'h3f},
        {`IDX_C_IE, 8'h00}, {`IDX_C_GPIO, 8'hff}, {`IDX_D_DS, 8'hff}, {`IDX_FSEL3, 8'h50}, {`IDX_FSEL0, 8'h00},
        {`IDX_FSEL6, 8'h00}};
    // mux table: pad, select byte, shift, function ids for codes 0, 1, 2
    logic [39:0] mux_tab[12] = '{40'h00_0_0_01_090e, 40'h01_0_2_02_1214,
        40'h03_0_6_16_1004, 40'h04_1_0_17_1105, 40'h08_2_0_06_0e1c,
        40'h09_2_2_07_0f1d, 40'h0e_3_4_22_1611, 40'h0f_3_6_23_150e,
        40'h10_4_0_24_0c11, 40'h13_4_6_04_0e25, 40'h15_5_2_0b_0e1b, 40'h18_6_0_1e_0013};
    logic [10:0] ie_idx[4] = '{`IDX_A_IE, `IDX_B_IE, `IDX_C_IE, `IDX_D_IE};
    logic [10:0] ds_idx[4] = '{`IDX_A_DS, `IDX_B_DS, `IDX_C_DS, `IDX_D_DS};

    pad_function_mux_gpio uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .func_out, .func_oe, .func_in, .pad_in, .pad_out, .pad_oe, .pad_drive_strength(pad_ds),
        .gpio_polarity(pad_pol));
    pad_world far (.pad_out, .pad_oe, .ext_level, .pad_in);

    // free-running clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // report one mismatch
    task automatic fail(input string msg);
        miscompares++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    task automatic chk_apb(input logic [8:0] exp);
        cmp_count++;
        if ({pslverr, prdata[7:0]} !== exp) fail("apb answer differs");
    endtask

    task automatic chk_pad(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) fail(what);
    endtask

    // one apb transfer; the request stays put until pready is seen, the note goes in the queue
    task automatic apb(input logic wr, input logic [10:0] idx, input logic [7:0] wd, input logic [8:0] exp);
        int n;
        n = 0;
        expq.push_back(exp);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {3'h0, idx, 2'h0};
        pwdata <= {24'($random(seed)), wd}; // upper bits are noise the block must ignore
        @(posedge pclk);
        penable <= 1'b1;
        // pready is sampled at the rising edge that completes the access
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail("no answer");
    endtask

    task automatic idle(input int c);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (c) @(posedge pclk);
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // answers are sampled mid-cycle, where they are settled, and matched to the oldest note
    always @(negedge pclk) if (pready === 1'b1) begin
        if (expq.size() == 0) fail("answer without request");
        else chk_apb(expq.pop_front());
    end

    // watchdog well beyond the expected run
    initial begin
        #(20000 * 8);
        fail("watchdog");
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        func_out = 38'h0;
        func_oe = 38'({$random(seed), $random(seed)});
        ext_level = $random(seed);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset state, refused accesses
        idle(2);
        chk_pad(pad_ds, 32'hffffffff, "drive reset");
        chk_pad(pad_oe, {16'h0, func_oe[21], func_oe[22], 6'h0, func_oe[26], 7'h0}, "default pads");
        foreach (rst_tab[i]) apb(1'b0, rst_tab[i][18:8], 8'h0, {1'b0, rst_tab[i][7:0]});
        apb(1'b0, 11'h587, 8'h0, 9'h100);
        apb(1'b0, 11'h5af, 8'h0, 9'h100);
        apb(1'b1, `IDX_A_LEVEL, 8'h5a, 9'h100);
        idle(1);
        $display("test reset done");
        // every select code of every tabled pad
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, ie_idx[p], 8'hff, 9'h0);
            apb(1'b1, 11'(11'h586 + 8 * p), 8'hff, 9'h0);
        end
        foreach (mux_tab[i]) begin
            e = mux_tab[i];
            pin = e[39:32];
            apb(1'b1, 11'(11'h586 + 8 * pin[4:3]), ~(8'h1 << pin[2:0]), 9'h0);
            for (int c = 0; c < 4; c++) begin
                apb(1'b1, 11'(11'h5a8 + e[31:28]), 8'(c) << e[27:24], 9'h0);
                id = (c == 3) ? 0 : int'(e[23 - 8 * c -: 8]);
                func_out <= 38'({$random(seed), $random(seed)});
                func_oe <= 38'({$random(seed), $random(seed)});
                ext_level <= $random(seed);
                idle(4);
                chk_pad(pad_oe[pin], (id == 0) ? 1'b0 : func_oe[id], "mux enable");
                chk_pad(pad_out[pin], (id == 0) ? 1'b0 : func_out[id], "mux output");
                if (id != 0) chk_pad(func_in[id], func_oe[id] ? func_out[id] : ext_level[pin], "mux input");
            end
        end
        $display("test mux done");
        // gpio mode with random settings on each port
        for (int p = 0; p < 4; p++) begin
            r = $random(seed);
            dis = r[7:0];
            nd = ~dis;
            lo = 8 * p;
            apb(1'b1, 11'(11'h586 + 8 * p), 8'hff, 9'h0);
            apb(1'b1, 11'(11'h582 + 8 * p), dis, 9'h0);
            apb(1'b1, 11'(11'h583 + 8 * p), r[15:8], 9'h0);
            apb(1'b1, ie_idx[p], r[23:16], 9'h0);
            apb(1'b1, 11'(11'h584 + 8 * p), r[31:24], 9'h0);
            apb(1'b1, ds_idx[p], nd, 9'h0);
            ext_level <= $random(seed);
            idle(4);
            chk_pad(pad_oe[lo +: 8], nd, "gpio enable");
            chk_pad(pad_out[lo +: 8] & nd, r[15:8] & nd, "gpio output");
            chk_pad(pad_pol[lo +: 8], r[31:24], "polarity");
            chk_pad(pad_ds[lo +: 8], nd, "drive");
            lvl = ((nd & r[15:8]) | (dis & ext_level[lo +: 8])) & r[23:16];
            apb(1'b0, 11'(11'h580 + 8 * p), 8'h0, {1'b0, lvl});
            apb(1'b0, 11'(11'h582 + 8 * p), 8'h0, {1'b0, dis});
            idle(1);
        end
        $display("test gpio done");
        idle(2);
        if (expq.size() != 0) fail("answers missing");
        complete_run();
    end
endmodule // pad_function_mux_gpio_bench
